// ==== core/bscc_map.svh ====
// bridge sensor correction core: timing counts, reset values, scalings
// assumes a 25 MHz core clock and the 512 kHz internal tick derived from it
`ifndef BSCC_MAP_SVH
`define BSCC_MAP_SVH

// clock rates in hz
`define BSCC_CLK_HZ      25000000
`define BSCC_TICK_HZ     512000

// idle time between packets per update rate code, in microseconds
`define BSCC_IDLE0_US    1000
`define BSCC_IDLE1_US    4850
`define BSCC_IDLE2_US    22500
`define BSCC_IDLE3_US    118000

// nonvolatile store programming time, in microseconds
`define BSCC_NV_PROG_US  6000

// reset values
`define BSCC_GAIN_NOM    2'h2

// fixed point: coefficients are q2.14 signed
`define BSCC_QSH         14
`define BSCC_ONE_Q14     32'sh4000
`define BSCC_K125_Q14    32'sh5000
`define BSCC_AZ_MID      32'sh2000
`define BSCC_BRIDGE_MAX  32'sh3fff
`define BSCC_T_MAX       32'sh0fff

`endif

// ==== core/bscc_pkg.sv ====
// bridge sensor correction core: shared types
// assumes nothing beyond the map header for numbers
package bscc_pkg;

  // pre-amp gain select: 6, 12, 24, 48
  typedef enum logic [1:0] {G6, G12, G24, G48} bscc_gain_type;

  // converter input channel
  typedef enum logic [1:0] {CH_BRIDGE, CH_TEMP, CH_AZERO} bscc_chan_type;

  // output mode
  typedef enum logic [1:0] {
    OM_RATIO, OM_ABS1V, OM_DIG_BRG, OM_DIG_BRG_T
  } bscc_omode_type;

  // target of the single second order term
  typedef enum logic [1:0] {
    TGT_BRIDGE, TGT_TCO, TGT_TCG, TGT_NONE
  } bscc_tgt_type;

  // configuration and coefficients read from the nonvolatile store
  typedef struct packed {
    bscc_gain_type      gain;
    logic               swap;
    logic [1:0]         zero_sel;
    logic [1:0]         rate;
    bscc_omode_type     omode;
    bscc_tgt_type       term_tgt;
    logic [3:0]         ref_trim_code;
    logic signed [15:0] gain_b;
    logic signed [15:0] off_b;
    logic signed [15:0] tcg;
    logic signed [15:0] tco;
    logic signed [15:0] second_order_term;
    logic signed [15:0] gain_t;
    logic signed [15:0] off_t;
    logic [11:0]        low_cal_temp_ref;
  } bscc_cfg_type;

  // conversion sequencer states
  typedef enum logic [2:0] {
    ST_IDLE, ST_AZERO, ST_TEMP, ST_BRIDGE, ST_CALC
  } bscc_fsm_type;

  // register state of the core, apart from the two reset synchroniser flops
  typedef struct packed {
    bscc_fsm_type   fsm;
    logic [5:0]     div;
    logic           tick;
    logic [16:0]    idle_cnt;
    logic [11:0]    nv_cnt;
    logic           nv_busy;
    logic           done_s1;
    logic           done_s2;
    logic           done_s3;
    logic           adc_start;
    bscc_chan_type  adc_chan;
    logic           sink_en;
    bscc_gain_type  gain;
    logic           swap;
    logic [1:0]     zero_sel;
    logic [3:0]     ref_trim_code;
    logic           dac_ref_1v;
    logic [13:0]    az;
    logic [13:0]    raw_bridge;
    logic [11:0]    raw_temp;
    logic [13:0]    corrected;
    logic [7:0]     temp_out;
    logic [10:0]    dac_code;
    logic           valid;
  } bscc_state_type;

endpackage

// ==== core/bscc_mulsh.sv ====
// bridge sensor correction core: signed multiply, shift, saturate
// assumes wa + wb exceeds wo; purely combinational
`timescale 1ns/1ps
module bscc_mulsh #(
  parameter int WA = 16,
  parameter int WB = 16,
  parameter int SH = 14,
  parameter int WO = 18
) (
  // operands
  input  wire logic signed [WA-1:0] a,
  input  wire logic signed [WB-1:0] b,
  // scaled product
  output logic signed [WO-1:0]      p
);
  localparam int WP = WA + WB;
  localparam logic signed [WP-1:0] PMAX =
    {{(WP-WO+1){1'b0}}, {(WO-1){1'b1}}};
  localparam logic signed [WP-1:0] PMIN =
    {{(WP-WO+1){1'b1}}, {(WO-1){1'b0}}};

  logic signed [WP-1:0] full;
  logic signed [WP-1:0] shr;

  // full product, then drop the fraction
  assign full = a * b;
  assign shr  = full >>> SH;

  // clamp instead of wrapping so overflow stays monotonic
  always_comb begin
    if (shr > PMAX) begin
      p = PMAX[WO-1:0];
    end else if (shr < PMIN) begin
      p = PMIN[WO-1:0];
    end else begin
      p = shr[WO-1:0];
    end
  end
endmodule

// ==== core/bscc_core.sv ====
// bridge sensor correction core: sequencer, correction math, outputs
// assumes cfg is held steady by the nonvolatile store and that the
// converter holds adc_data steady while adc_done is high
//
// Operation
// RL1: raw temperature is upper 12 converter bits
// RL2: temperature output is its 8 msbs
// RL3: bridge sink on only during bridge conversion
// RL4: pre-amp gain 6/12/24/48, nominal 24
// RL5: config bit swaps bridge inputs
// RL6: 14-bit results, four zero points
// RL7: conversion rate follows update rate, 1ms fastest
// RL8: auto-zero conversion cancels pre-amp drift
// RL9: second order term hits at most one target; term_tgt TGT_NONE applies it to none
// RL10: bridge target: intermediate times (1.25+term*intermediate)
// RL11: dT is raw temp minus low cal ref
// RL12: coefficient target: coefficient becomes term*dT+coefficient
// RL13: temperature is gain times (raw plus offset)
// RL14: store supplies coefficients, mode, update rate
// RL15: store write programs for 6ms
// RL16: raw results available for serial commands
// RL17: 11-bit output converter gets corrected bridge
// RL18: absolute mode selects trimmed 1V reference
// RL19: 4-bit trim code adjusts 1V reference
// RL20: 512kHz internal tick paces all timing
// RL21: update rate code selects packet idle time
// RL22: corrected bridge saturates to 14 bits
`timescale 1ns/1ps
`include "bscc_map.svh"
module bscc_core #(
  parameter int DIV_N   = `BSCC_CLK_HZ / `BSCC_TICK_HZ,
  parameter int IDLE0_T = `BSCC_IDLE0_US * 512 / 1000,
  parameter int IDLE1_T = `BSCC_IDLE1_US * 512 / 1000,
  parameter int IDLE2_T = `BSCC_IDLE2_US * 512 / 1000,
  parameter int IDLE3_T = `BSCC_IDLE3_US * 512 / 1000,
  parameter int NV_T    = `BSCC_NV_PROG_US * 512 / 1000
) (
  // clock and reset
  input  wire logic                    core_clk,
  input  wire logic                    rst_b,
  // nonvolatile store contents and write request
  input  wire bscc_pkg::bscc_cfg_type  cfg,
  input  wire logic                    nv_wr_req,
  output logic                         nv_busy,
  // converter and analog front end
  input  wire logic                    adc_done,
  input  wire logic [13:0]             adc_data,
  output logic                         adc_start,
  output bscc_pkg::bscc_chan_type      adc_chan,
  output logic                         sink_en,
  output bscc_pkg::bscc_gain_type      preamp_gain,
  output logic                         input_swap,
  output logic [1:0]                   zero_sel,
  // output stage
  output logic [10:0]                  dac_code,
  output logic                         dac_ref_1v,
  output logic [3:0]                   ref_trim_code,
  // results
  output logic [13:0]                  raw_bridge,
  output logic [11:0]                  raw_temp,
  output logic [13:0]                  corrected,
  output logic [7:0]                   temp_out,
  output logic                         result_valid
);
  localparam int W = `BSCC_QSH;

  logic [1:0]                    rst_sync;
  logic                          rst_n;
  bscc_pkg::bscc_state_type      st_r;
  bscc_pkg::bscc_state_type      st_nxt;
  logic                          done_edge;
  logic [16:0]                   idle_lim;
  logic signed [15:0]            az_fix;
  logic [13:0]                   az_sat;
  logic signed [12:0]            dt;
  logic signed [15:0]            term_dt;
  logic signed [16:0]            tcg_eff;
  logic signed [16:0]            tco_eff;
  logic signed [17:0]            g_term;
  logic signed [17:0]            o_term;
  logic signed [18:0]            gfac;
  logic signed [19:0]            osum;
  logic signed [19:0]            gb;
  logic signed [19:0]            inter;
  logic signed [19:0]            s_term;
  logic signed [20:0]            sfac;
  logic signed [19:0]            corr2;
  logic signed [19:0]            corr_pre;
  logic [13:0]                   corr_sat;
  logic signed [16:0]            tsum;
  logic signed [13:0]            t_full;
  logic [11:0]                   t_sat;

  // reset release through two flops, assertion stays asynchronous
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // converter finished: rising edge after the two-flop synchroniser
  assign done_edge = st_r.done_s2 & ~st_r.done_s3;

  // idle time in 512 kHz ticks per update rate code
  always_comb begin
    unique case (cfg.rate) // RL14
      2'h0: idle_lim = 17'(IDLE0_T); // RL7
      2'h1: idle_lim = 17'(IDLE1_T); // RL21
      2'h2: idle_lim = 17'(IDLE2_T);
      2'h3: idle_lim = 17'(IDLE3_T);
    endcase
  end

  // bridge reading less the auto-zero reading, re-centred on mid scale, clamped to 14 bits
  assign az_fix = $signed({2'h0, adc_data}) - $signed({2'h0, st_r.az})
                + 16'(`BSCC_AZ_MID); // RL8
  assign az_sat = (az_fix < 16'sh0000) ? 14'h0000 :
                  (az_fix > 16'(`BSCC_BRIDGE_MAX)) ? 14'h3fff : az_fix[13:0];

  // temperature difference to the low calibration point
  assign dt = $signed({1'b0, st_r.raw_temp})
            - $signed({1'b0, cfg.low_cal_temp_ref}); // RL11

  // second order term folded into one coefficient only
  bscc_mulsh #(.WA(16), .WB(13), .SH(W), .WO(16)) u_term_dt (
    .a (cfg.second_order_term),
    .b (dt),
    .p (term_dt)
  );
  assign tcg_eff = (cfg.term_tgt == bscc_pkg::TGT_TCG) ?
                   17'(cfg.tcg) + 17'(term_dt) : 17'(cfg.tcg); // RL12
  assign tco_eff = (cfg.term_tgt == bscc_pkg::TGT_TCO) ?
                   17'(cfg.tco) + 17'(term_dt) : 17'(cfg.tco); // RL12

  // gain factor 1 + dT*tcg
  bscc_mulsh #(.WA(13), .WB(17), .SH(W), .WO(18)) u_g_term (
    .a (dt),
    .b (tcg_eff),
    .p (g_term)
  );
  assign gfac = 19'(`BSCC_ONE_Q14) + 19'(g_term);

  // offset sum raw + offset + dT*tco
  bscc_mulsh #(.WA(13), .WB(17), .SH(W), .WO(18)) u_o_term (
    .a (dt),
    .b (tco_eff),
    .p (o_term)
  );
  assign osum = $signed({6'h00, st_r.raw_bridge}) + 20'(cfg.off_b)
              + 20'(o_term);

  // intermediate = gain * factor * sum
  bscc_mulsh #(.WA(16), .WB(19), .SH(W), .WO(20)) u_gb (
    .a (cfg.gain_b),
    .b (gfac),
    .p (gb)
  );
  bscc_mulsh #(.WA(20), .WB(20), .SH(W), .WO(20)) u_inter (
    .a (gb),
    .b (osum),
    .p (inter)
  );

  // bridge target: intermediate * (1.25 + term * intermediate)
  bscc_mulsh #(.WA(16), .WB(20), .SH(W), .WO(20)) u_s_term (
    .a (cfg.second_order_term),
    .b (inter),
    .p (s_term)
  );
  assign sfac = 21'(`BSCC_K125_Q14) + 21'(s_term); // RL10
  bscc_mulsh #(.WA(20), .WB(21), .SH(W), .WO(20)) u_corr2 (
    .a (inter),
    .b (sfac),
    .p (corr2)
  );

  // only one target takes the term; others pass the intermediate
  assign corr_pre = (cfg.term_tgt == bscc_pkg::TGT_BRIDGE) ?
                    corr2 : inter; // RL9
  // clamp rather than wrap when the corrected bridge leaves 14 bits
  assign corr_sat = (corr_pre < 20'sh00000) ? 14'h0000 :
                    (corr_pre > 20'(`BSCC_BRIDGE_MAX)) ? 14'h3fff :
                    corr_pre[13:0]; // RL22

  // temperature: linear gain and offset, no second order term
  assign tsum = $signed({5'h00, st_r.raw_temp}) + 17'(cfg.off_t); // RL13
  bscc_mulsh #(.WA(16), .WB(17), .SH(W), .WO(14)) u_temp (
    .a (cfg.gain_t),
    .b (tsum),
    .p (t_full)
  );
  assign t_sat = (t_full < 14'sh0000) ? 12'h000 :
                 (t_full > 14'(`BSCC_T_MAX)) ? 12'hfff : t_full[11:0];

  // next state: sequencer, tick divider, store write timer
  always_comb begin
    st_nxt           = st_r;
    st_nxt.adc_start = 1'b0;
    st_nxt.valid     = 1'b0;
    st_nxt.tick      = 1'b0;
    st_nxt.done_s1   = adc_done;
    st_nxt.done_s2   = st_r.done_s1;
    st_nxt.done_s3   = st_r.done_s2;
    // 512 kHz tick as a one-cycle enable
    if (st_r.div == 6'(DIV_N - 1)) begin
      st_nxt.div  = 6'h00;
      st_nxt.tick = 1'b1; // RL20
    end else begin
      st_nxt.div = st_r.div + 6'h01;
    end
    // front end and reference settings follow the store
    st_nxt.gain          = cfg.gain; // RL4
    st_nxt.swap          = cfg.swap; // RL5
    st_nxt.zero_sel      = cfg.zero_sel; // RL6
    st_nxt.ref_trim_code = cfg.ref_trim_code; // RL19
    st_nxt.dac_ref_1v    = (cfg.omode == bscc_pkg::OM_ABS1V); // RL18
    unique case (st_r.fsm)
      bscc_pkg::ST_IDLE: begin
        if (st_r.tick) begin
          st_nxt.idle_cnt = st_r.idle_cnt + 17'h00001;
        end
        if (st_r.idle_cnt >= idle_lim) begin
          st_nxt.idle_cnt  = 17'h00000;
          st_nxt.fsm       = bscc_pkg::ST_AZERO;
          st_nxt.adc_start = 1'b1;
          st_nxt.adc_chan  = bscc_pkg::CH_AZERO; // RL8
        end
      end
      bscc_pkg::ST_AZERO: begin
        if (done_edge) begin
          st_nxt.az        = adc_data;
          st_nxt.fsm       = bscc_pkg::ST_TEMP;
          st_nxt.adc_start = 1'b1;
          st_nxt.adc_chan  = bscc_pkg::CH_TEMP;
        end
      end
      bscc_pkg::ST_TEMP: begin
        if (done_edge) begin
          st_nxt.raw_temp  = adc_data[13:2]; // RL1
          st_nxt.fsm       = bscc_pkg::ST_BRIDGE;
          st_nxt.adc_start = 1'b1;
          st_nxt.adc_chan  = bscc_pkg::CH_BRIDGE;
          st_nxt.sink_en   = 1'b1; // RL3
        end
      end
      bscc_pkg::ST_BRIDGE: begin
        if (done_edge) begin
          st_nxt.raw_bridge = az_sat; // RL16
          st_nxt.sink_en    = 1'b0; // RL3
          st_nxt.fsm        = bscc_pkg::ST_CALC;
        end
      end
      bscc_pkg::ST_CALC: begin
        st_nxt.corrected = corr_sat;
        st_nxt.temp_out  = t_sat[11:4]; // RL2
        st_nxt.dac_code  = corr_sat[13:3]; // RL17
        st_nxt.valid     = 1'b1;
        st_nxt.fsm       = bscc_pkg::ST_IDLE;
      end
      default: begin
        st_nxt.fsm     = bscc_pkg::ST_IDLE;
        st_nxt.sink_en = 1'b0;
      end
    endcase
    // store programming window; requests while busy are ignored
    if (nv_wr_req && !st_r.nv_busy) begin
      st_nxt.nv_busy = 1'b1; // RL15
      st_nxt.nv_cnt  = 12'h000;
    end else if (st_r.nv_busy && st_r.tick) begin
      if (st_r.nv_cnt == 12'(NV_T - 1)) begin
        st_nxt.nv_busy = 1'b0; // RL15
      end else begin
        st_nxt.nv_cnt = st_r.nv_cnt + 12'h001;
      end
    end
  end

  // single state register
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r      <= '0;
      st_r.gain <= bscc_pkg::bscc_gain_type'(`BSCC_GAIN_NOM); // RL4
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from the state register
  assign nv_busy       = st_r.nv_busy;
  assign adc_start     = st_r.adc_start;
  assign adc_chan      = st_r.adc_chan;
  assign sink_en       = st_r.sink_en;
  assign preamp_gain   = st_r.gain;
  assign input_swap    = st_r.swap;
  assign zero_sel      = st_r.zero_sel;
  assign dac_code      = st_r.dac_code;
  assign dac_ref_1v    = st_r.dac_ref_1v;
  assign ref_trim_code = st_r.ref_trim_code;
  assign raw_bridge    = st_r.raw_bridge;
  assign raw_temp      = st_r.raw_temp;
  assign corrected     = st_r.corrected;
  assign temp_out      = st_r.temp_out;
  assign result_valid  = st_r.valid;

  // checks on the sequencer and the results
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  temp_bits_a: assert property ( // RL1
    (st_r.fsm == bscc_pkg::ST_TEMP && done_edge)
      |=> st_r.raw_temp == $past(adc_data[13:2]))
    else $error("raw temperature not upper 12 bits");
  temp_out_a: assert property ( // RL2
    st_r.valid |-> st_r.temp_out == $past(t_sat[11:4]))
    else $error("temperature output not top 8 bits");
  sink_conv_a: assert property ( // RL3
    st_r.sink_en |-> st_r.fsm == bscc_pkg::ST_BRIDGE)
    else $error("bridge sink on outside bridge conversion");
  sink_start_a: assert property ( // RL3
    (st_r.adc_start && st_r.adc_chan == bscc_pkg::CH_BRIDGE)
      |-> st_r.sink_en)
    else $error("bridge conversion started without sink");
  az_first_a: assert property ( // RL8
    (st_r.fsm == bscc_pkg::ST_IDLE ##1 st_r.fsm != bscc_pkg::ST_IDLE)
      |-> st_r.fsm == bscc_pkg::ST_AZERO
          && st_r.adc_chan == bscc_pkg::CH_AZERO && st_r.adc_start)
    else $error("sequence did not open with auto-zero");
  idle_time_a: assert property ( // RL21
    (st_r.fsm == bscc_pkg::ST_IDLE && $stable(cfg.rate))
      |-> st_r.idle_cnt <= idle_lim)
    else $error("idle count ran past update rate limit");
  nv_time_a: assert property ( // RL15
    $fell(st_r.nv_busy) |-> $past(st_r.nv_cnt) == 12'(NV_T - 1))
    else $error("store write window wrong length");
  sat_high_a: assert property ( // RL22
    (st_r.fsm == bscc_pkg::ST_CALC && corr_pre > 20'(`BSCC_BRIDGE_MAX))
      |=> st_r.corrected == 14'h3fff)
    else $error("corrected bridge wrapped instead of clamping");
  dac_code_a: assert property ( // RL17
    st_r.valid |-> st_r.dac_code == st_r.corrected[13:3])
    else $error("dac code not taken from corrected bridge");
  ref_sel_a: assert property ( // RL18
    (cfg.omode == bscc_pkg::OM_ABS1V) |=> st_r.dac_ref_1v)
    else $error("absolute mode without 1V reference");
endmodule

// ==== tb/bscc_adc_model.sv ====
// converter and bridge front end model facing the correction core
// assumes the core's clock; answers lat plus one cycles after each start pulse
`timescale 1ns/1ps
module bscc_adc_model (
  // clock and reset
  input  wire logic                    core_clk,
  input  wire logic                    rst_b,
  // core side of the converter link
  input  wire logic                    adc_start,
  input  wire bscc_pkg::bscc_chan_type adc_chan,
  output logic                         adc_done,
  output logic [13:0]                  adc_data,
  // readings per channel and answer delay
  input  wire logic [13:0]             az_val,
  input  wire logic [13:0]             temp_val,
  input  wire logic [13:0]             brg_val,
  input  wire logic [7:0]              lat,
  // bridge conversion under way, done not yet raised
  output logic                         conv_brg
);
  bscc_pkg::bscc_chan_type ch;
  int                      cnt;
  logic [13:0]             pick;

  // reading of the channel being converted
  always_comb begin
    pick = (ch == bscc_pkg::CH_AZERO) ? az_val :
           (ch == bscc_pkg::CH_TEMP) ? temp_val : brg_val;
  end

  // done stays up five cycles, longer than the core's sync and sample;
  // a new start drops it so the core always sees a fresh rising edge
  always @(negedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt      <= 0;
      adc_done <= 1'b0;
      adc_data <= 14'h0;
      conv_brg <= 1'b0;
    end else if (adc_start) begin
      ch       <= adc_chan;
      cnt      <= lat + 5;
      adc_done <= 1'b0;
      conv_brg <= (adc_chan == bscc_pkg::CH_BRIDGE);
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
      if (cnt > 5) begin
        adc_data <= ~adc_data;
      end
      if (cnt == 5) begin
        adc_done <= 1'b1;
        adc_data <= pick;
        conv_brg <= 1'b0;
      end
    end else begin
      // released data lines toggle so a stale value never matches
      adc_done <= 1'b0;
      adc_data <= ~adc_data;
    end
  end
endmodule

// ==== tb/bscc_core_test.sv ====
// self-checking bench for the bridge sensor correction core
// assumes bscc_adc_model as converter; inputs change at falling edges
`timescale 1ns/1ps
module bscc_core_test;
  localparam int DIV = 2;
  localparam int NVT = 5;
  localparam int IT [4] = '{4, 6, 8, 10};
  logic                   core_clk = 1'b0;
  logic                   rst_b = 1'b0;
  logic                   nv_wr_req = 1'b0;
  bscc_pkg::bscc_cfg_type cfg = '0;
  logic [13:0]            az_val = 14'h2000;
  logic [13:0]            temp_val = 14'h0;
  logic [13:0]            brg_val = 14'h0;
  logic [7:0]             lat = 8'h2;
  logic [13:0]            adc_data, raw_bridge, corrected;
  logic [11:0]            raw_temp;
  logic [10:0]            dac_code;
  logic [7:0]             temp_out;
  logic [3:0]             ref_trim_code;
  logic [1:0]             zero_sel;
  logic                   nv_busy, adc_done, adc_start, sink_en, conv_brg;
  logic                   input_swap, dac_ref_1v, result_valid;
  bscc_pkg::bscc_chan_type adc_chan;
  bscc_pkg::bscc_gain_type preamp_gain;
  int                     n_errors = 0;
  int                     num_checks = 0;
  int                     nst = 0;

  always #20 core_clk = ~core_clk;

  bscc_core #(.DIV_N(DIV), .IDLE0_T(4), .IDLE1_T(6), .IDLE2_T(8),
    .IDLE3_T(10), .NV_T(NVT)) DUT (.core_clk(core_clk), .rst_b(rst_b),
    .cfg(cfg), .nv_wr_req(nv_wr_req), .nv_busy(nv_busy),
    .adc_done(adc_done), .adc_data(adc_data), .adc_start(adc_start),
    .adc_chan(adc_chan), .sink_en(sink_en), .preamp_gain(preamp_gain),
    .input_swap(input_swap), .zero_sel(zero_sel), .dac_code(dac_code),
    .dac_ref_1v(dac_ref_1v), .ref_trim_code(ref_trim_code),
    .raw_bridge(raw_bridge), .raw_temp(raw_temp), .corrected(corrected),
    .temp_out(temp_out), .result_valid(result_valid));

  bscc_adc_model m (.core_clk(core_clk), .rst_b(rst_b),
    .adc_start(adc_start), .adc_chan(adc_chan), .adc_done(adc_done),
    .adc_data(adc_data), .az_val(az_val), .temp_val(temp_val),
    .brg_val(brg_val), .lat(lat), .conv_brg(conv_brg));

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_cnt(input int got, input int lo, input int hi);
    num_checks++;
    if (got < lo || got > hi) begin
      n_errors++;
      $display("unexpected at %0t: got %h exp %h..%h", $time, got, lo, hi);
    end
  endtask

  // bounded wait for a result pulse or an autozero start
  task automatic wait_for(input bit strt, output int c);
    c = 0;
    do begin
      @(negedge core_clk);
      c++;
      if (c > 3000) begin
        n_errors++;
        wrap_up();
      end
    end while (strt ? !(adc_start === 1'b1 &&
      adc_chan === bscc_pkg::CH_AZERO) : result_valid !== 1'b1);
  endtask

  function automatic logic [31:0] nx(input logic [31:0] s);
    return s[0] ? (s >> 1) ^ 32'h80200003 : s >> 1;
  endfunction

  function automatic logic signed [47:0] pr(input logic signed [47:0] a,
                                            input logic signed [47:0] b);
    return (a * b) >>> 14;
  endfunction

  function automatic logic [13:0] clp(input logic signed [47:0] v,
                                      input int mx);
    return (v < 0) ? 14'h0 : (v > mx) ? 14'(mx) : v[13:0];
  endfunction

  // corrected bridge worked out in q2.14, clamped to 14 bits
  function automatic logic [13:0] e_corr(input logic [13:0] rb,
    input logic [11:0] rt, input bscc_pkg::bscc_cfg_type c);
    logic signed [47:0] dt, tg, to, z;
    dt = $signed({36'h0, rt}) - $signed({36'h0, c.low_cal_temp_ref});
    tg = c.tcg;
    to = c.tco;
    if (c.term_tgt == bscc_pkg::TGT_TCO) begin
      to = pr(c.second_order_term, dt) + to;
    end
    if (c.term_tgt == bscc_pkg::TGT_TCG) begin
      tg = pr(c.second_order_term, dt) + tg;
    end
    z = pr(pr(c.gain_b, 48'sd16384 + pr(dt, tg)),
      $signed({34'h0, rb}) + c.off_b + pr(dt, to));
    if (c.term_tgt == bscc_pkg::TGT_BRIDGE) begin
      z = pr(z, 48'sd20480 + pr(c.second_order_term, z));
    end
    return clp(z, 16383);
  endfunction

  // order of conversions and sink timing, watched every cycle
  always @(negedge core_clk) begin
    if (rst_b && adc_start === 1'b1) begin
      chk(adc_chan, nst % 3 == 0 ? bscc_pkg::CH_AZERO : nst % 3 == 1 ?
        bscc_pkg::CH_TEMP : bscc_pkg::CH_BRIDGE);
      if (adc_chan !== bscc_pkg::CH_BRIDGE) chk(sink_en, 1'b0);
      nst++;
    end
    if (conv_brg) chk(sink_en, 1'b1);
  end

  initial begin
    int          k, c;
    logic [31:0] s;
    logic [13:0] rb, t;
    s = 32'h022a8dc3;
    repeat (12) @(negedge core_clk);
    chk(preamp_gain, bscc_pkg::G24);
    rst_b = 1'b1;
    repeat (4) @(negedge core_clk);
    // store write, with a second request inside the window refused
    nv_wr_req = 1'b1;
    @(negedge core_clk);
    nv_wr_req = 1'b0;
    chk(nv_busy, 1'b1);
    c = 1;
    while (nv_busy === 1'b1 && c < 100) begin
      nv_wr_req = (c == 4);
      @(negedge core_clk);
      c++;
    end
    nv_wr_req = 1'b0;
    chk_cnt(c, NVT * DIV - DIV, NVT * DIV + DIV + 1);
    $display("test store done");
    wait_for(1'b1, c);
    // sixteen sequences walk every gain, rate, mode and term target
    for (k = 0; k < 16; k++) begin
      s = nx(nx(s));
      cfg.gain = bscc_pkg::bscc_gain_type'(k[3:2]);
      cfg.swap = s[0];
      cfg.zero_sel = s[2:1];
      cfg.rate = k[3:2] ^ k[1:0];
      cfg.omode = bscc_pkg::bscc_omode_type'(k[2:1]);
      cfg.term_tgt = bscc_pkg::bscc_tgt_type'(k[1:0]);
      cfg.ref_trim_code = s[6:3];
      cfg.gain_b = 16'sh4000;
      cfg.off_b = (k == 2) ? -16'sh7000 : 16'(s[15:9]) - 16'h40;
      cfg.tcg = s[16] ? 16'sh4000 : 16'sh0;
      cfg.tco = s[17] ? 16'sh4000 : 16'sh0;
      cfg.second_order_term = (k[1:0] == 0) ? {12'h0, s[21:18]} : 16'sh4000;
      cfg.gain_t = {3'b001, s[12:0]};
      cfg.off_t = 16'(s[7:0]) - 16'h80;
      temp_val = {2'b01, s[27:16]};
      cfg.low_cal_temp_ref = temp_val[13:2] + 12'(s[5:0]) - 12'h20;
      s = nx(s);
      az_val = (k == 1) ? 14'h3fff : (k == 0) ? 14'h0 : 14'h1f80 + s[7:0];
      brg_val = (k == 0) ? 14'h3fff : (k == 1) ? 14'h0 : s[31:18];
      lat = (k == 3) ? 8'h0 : {2'b00, s[13:8]};
      rb = clp(48'(brg_val) - 48'(az_val) + 48'sd8192, 16383);
      // signed sum so a negative offset is sign-extended
      t = clp(pr(cfg.gain_t, $signed({36'h0, temp_val[13:2]})
        + cfg.off_t), 4095);
      wait_for(1'b0, c);
      chk(raw_bridge, rb);
      chk(raw_temp, temp_val[13:2]);
      chk(corrected, e_corr(rb, temp_val[13:2], cfg));
      chk(temp_out, t[11:4]);
      chk(dac_code, e_corr(rb, temp_val[13:2], cfg) >> 3);
      chk(dac_ref_1v, cfg.omode == bscc_pkg::OM_ABS1V);
      chk({preamp_gain, input_swap, zero_sel, ref_trim_code}, {cfg.gain,
        cfg.swap, cfg.zero_sel, cfg.ref_trim_code});
      chk(sink_en, 1'b0);
      wait_for(1'b1, c);
      chk_cnt(c, IT[cfg.rate] * DIV - DIV,
        IT[cfg.rate] * DIV + 2 * DIV + 1);
      $display("test %0d done", k);
    end
    wrap_up();
  end
endmodule
